// [design/dimming_defs.vh]
// constants shared by the dimming angle and fault supervisor
`ifndef DIMMING_DEFS_VH
`define DIMMING_DEFS_VH

`define CLK_PERIOD_NS 10
`define OVP_QUAL_NS 20000
`define OVP_QUAL_CYC ((`OVP_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TF_BLANK_NS 300000
`define TF_BLANK_CYC ((`TF_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ZCD_TIMEOUT_NS 40000
`define ZCD_TIMEOUT_CYC (`ZCD_TIMEOUT_NS / `CLK_PERIOD_NS)

`define SHORT_TRIP_COUNT 3'd4
`define ANGLE_LOCK_CYCLES 6'd32
`define IIR_SHIFT 2

// codes are 8 bit, full scale = peak current limit
`define MIN_PEAK_CODE 8'h59
`define TF_START_CODE 8'h80
`define TF_TENTH_CODE 8'h40
`define REF_TENTH_Q8 10'h01a
`define TF_SLOPE_Q4 10'h03a
`define REF_STOP_Q8 10'h00d

// synchronised input bit positions
`define IN_DIM 0
`define IN_VALLEY 1
`define IN_TON_END 2
`define IN_PEAK 3
`define IN_SHORT 4
`define IN_ZCD 5
`define IN_OVP_HI 6
`define IN_OVP_RST 7
`define IN_DIV_MISS 8
`define IN_VCC_ON 9
`define IN_VCC_RST 10
`define IN_COUNT 11

`endif

// [design/angle_divider.v]
// sequential fractional divider: quotient = 256 * num / den for num < den, 8'hff when num == den
`include "dimming_defs.vh"
module angle_divider (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // request
  input wire start,
  input wire [20:0] num,
  input wire [20:0] den,
  // answer
  output reg done_q,
  output reg [7:0] quot_q
);
  reg [21:0] rem_q;
  reg [20:0] den_q;
  reg [3:0] step_q;
  reg busy_q;
  wire [21:0] rem_sh = {rem_q[20:0], 1'b0};
  wire take = rem_sh >= {1'b0, den_q};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= 22'h000000;
      den_q <= 21'h000000;
      step_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      quot_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        rem_q <= {1'b0, num};
        den_q <= den;
        step_q <= 4'h0;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= take ? (rem_sh - {1'b0, den_q}) : rem_sh;
        quot_q <= {quot_q[6:0], take};
        step_q <= step_q + 4'h1;
        if (step_q == 4'h7) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule // angle_divider

// [design/angle_filter.v]
// iir smoothing of the angle with a hold of several mains cycles
`include "dimming_defs.vh"
module angle_filter (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // new raw angle and mains cycle tick
  input wire sample,
  input wire [7:0] raw,
  input wire mains_tick,
  // held angle
  output reg [7:0] held_q
);
  reg [9:0] acc_q;
  reg [5:0] lock_q;
  wire [9:0] raw_x = {raw, 2'b00};
  wire [9:0] acc_d = acc_q + (raw_x >> `IIR_SHIFT) - (acc_q >> `IIR_SHIFT);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 10'h000;
      lock_q <= 6'h00;
      held_q <= 8'h00;
    end else begin
      if (sample)
        acc_q <= acc_d;
      if (mains_tick) begin
        if (lock_q >= `ANGLE_LOCK_CYCLES - 6'd1) begin
          lock_q <= 6'h00;
          held_q <= acc_q[9:2];
        end else begin
          lock_q <= lock_q + 6'h01;
        end
      end
    end
  end
endmodule // angle_filter

// [design/dimming_angle_and_fault_control.v]
// dimmer angle measurement, reference shaping and fault supervision
`include "dimming_defs.vh"
module dimming_angle_and_fault_control #(
  parameter TF_BLANK_CYCLES = `TF_BLANK_CYC,
  parameter ZCD_TIMEOUT_CYCLES = `ZCD_TIMEOUT_CYC
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // comparator inputs from the analog front end, asynchronous
  input wire conduction_sense_input,
  input wire mains_valley_input,
  input wire on_time_end,
  input wire peak_trip,
  input wire winding_short_trip,
  input wire zero_crossing_event,
  input wire ovp_above_off,
  input wire ovp_below_on,
  input wire divider_missing,
  input wire supply_on,
  input wire supply_reset,
  // thermal a/d code, same clock
  input wire [7:0] thermal_sense_input,
  // power switch
  output reg gate_drive_q,
  // set-points and angle
  output reg [7:0] conduction_angle_q,
  output reg [7:0] reference_code_q,
  output reg [7:0] peak_setpoint_q,
  // fault status
  output reg ovp_fault_q,
  output reg short_latch_q,
  output reg divider_latch_q,
  output reg thermal_stop_q,
  output reg stopped_q
);
  // switching cycle states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_ON = 3'b010;
  localparam ST_OFF = 3'b100;


  // floor applied to the peak set-point
  function [7:0] max8;
    input [7:0] a;
    input [7:0] b;
    max8 = (a > b) ? a : b;
  endfunction

  // q8 scaling, saturates so a factor above one cannot wrap
  function [7:0] scale8;
    input [7:0] code;
    input [9:0] q8;
    reg [17:0] p;
    begin
      p = code * q8;
      scale8 = (p[17:8] > 10'h0ff) ? 8'hff : p[15:8];
    end
  endfunction

  // three stage synchroniser, value taken when stages two and three agree
  reg [`IN_COUNT-1:0] s1_q;
  reg [`IN_COUNT-1:0] s2_q;
  reg [`IN_COUNT-1:0] s3_q;
  reg [`IN_COUNT-1:0] in_q;
  reg [`IN_COUNT-1:0] prev_q;
  wire [`IN_COUNT-1:0] raw_in = {supply_reset, supply_on, divider_missing, ovp_below_on,
    ovp_above_off, zero_crossing_event, winding_short_trip, peak_trip, on_time_end,
    mains_valley_input, conduction_sense_input};
  wire [`IN_COUNT-1:0] rise = in_q & ~prev_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {`IN_COUNT{1'b0}};
      s2_q <= {`IN_COUNT{1'b0}};
      s3_q <= {`IN_COUNT{1'b0}};
      in_q <= {`IN_COUNT{1'b0}};
      prev_q <= {`IN_COUNT{1'b0}};
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & in_q);
      prev_q <= in_q;
    end
  end


  // conduction level and half period boundary
  wire dim_flag = in_q[`IN_DIM];
  wire half_tick = rise[`IN_VALLEY];

  // conduction and period counters, two halves summed each half period
  reg [19:0] half_on_q;
  reg [19:0] half_all_q;
  reg [19:0] last_on_q;
  reg [19:0] last_all_q;
  reg [20:0] smp_on_q;
  reg [20:0] smp_all_q;
  reg div_go_q;
  reg half_par_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_on_q <= 20'h00000;
      half_all_q <= 20'h00000;
      last_on_q <= 20'h00000;
      last_all_q <= 20'h00000;
      smp_on_q <= 21'h000000;
      smp_all_q <= 21'h000000;
      div_go_q <= 1'b0;
      half_par_q <= 1'b0;
    end else begin
      div_go_q <= 1'b0;
      if (half_tick) begin
        smp_on_q <= {1'b0, half_on_q} + {1'b0, last_on_q};
        smp_all_q <= {1'b0, half_all_q} + {1'b0, last_all_q};
        last_on_q <= half_on_q;
        last_all_q <= half_all_q;
        half_on_q <= {19'h00000, dim_flag};
        half_all_q <= 20'h00001;
        div_go_q <= (half_all_q != 20'h00000);
        half_par_q <= ~half_par_q;
      end else begin
        if (dim_flag && half_on_q != 20'hfffff)
          half_on_q <= half_on_q + 20'h00001;
        if (half_all_q != 20'hfffff)
          half_all_q <= half_all_q + 20'h00001;
      end
    end
  end

  wire div_done;
  wire [7:0] div_quot;
  wire [7:0] angle_held;

  // divider runs once per half period, well inside the next one
  angle_divider u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(div_go_q),
    .num(smp_on_q),
    .den(smp_all_q),
    .done_q(div_done),
    .quot_q(div_quot)
  );

  // full rectified-mains cycles are counted on every valley edge
  angle_filter u_filt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sample(div_done),
    .raw(div_quot),
    .mains_tick(half_tick),
    .held_q(angle_held)
  );

  // thermal blanking after supply reaches turn-on
  reg [14:0] blank_q;
  reg blanked_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_q <= 15'h0000;
      blanked_q <= 1'b1;
    end else if (!in_q[`IN_VCC_ON]) begin
      blank_q <= 15'h0000;
      blanked_q <= 1'b1;
    end else if (blanked_q) begin
      if (blank_q >= TF_BLANK_CYCLES[14:0] - 15'h0001)
        blanked_q <= 1'b0;
      else
        blank_q <= blank_q + 15'h0001;
    end
  end

  // linear fold-back through start (100 %) and tenth (10 %) points
  reg [9:0] tf_scale;
  reg [17:0] tf_prod;
  always @* begin
    tf_prod = 18'h00000;
    tf_scale = 10'h100;
    if (!blanked_q && thermal_sense_input < `TF_START_CODE) begin
      if (thermal_sense_input >= `TF_TENTH_CODE) begin
        tf_prod = (thermal_sense_input - `TF_TENTH_CODE) * `TF_SLOPE_Q4;
        tf_scale = `REF_TENTH_Q8 + tf_prod[13:4];
      end else begin
        tf_prod = thermal_sense_input * `REF_TENTH_Q8;
        tf_scale = {4'h0, tf_prod[11:6]};
      end
    end
  end

  // fold-back acts without delay; only blanking holds it back
  wire [7:0] ref_d = scale8(angle_held, tf_scale);
  wire tf_stop = !blanked_q && (tf_scale < `REF_STOP_Q8);

  // fault supervision
  reg [10:0] ovp_cnt_q;
  reg [2:0] short_cnt_q;
  reg short_seen_q;
  reg [2:0] state_q;
  reg [15:0] zcd_cnt_q;
  // a sagging supply counts as a stop so no cycle starts on a weak rail
  wire any_stop = ovp_fault_q | short_latch_q | divider_latch_q | thermal_stop_q |
    !in_q[`IN_VCC_ON];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovp_cnt_q <= 11'h000;
      ovp_fault_q <= 1'b0;
      divider_latch_q <= 1'b0;
      short_latch_q <= 1'b0;
      thermal_stop_q <= 1'b0;
      conduction_angle_q <= 8'h00;
      reference_code_q <= 8'h00;
      peak_setpoint_q <= `MIN_PEAK_CODE;
    end else begin
      conduction_angle_q <= angle_held;
      reference_code_q <= ref_d;
      peak_setpoint_q <= max8(ref_d, `MIN_PEAK_CODE);
      thermal_stop_q <= tf_stop;
      if (in_q[`IN_OVP_HI] && !ovp_fault_q) begin
        if (ovp_cnt_q >= `OVP_QUAL_CYC - 1)
          ovp_fault_q <= 1'b1;
        else
          ovp_cnt_q <= ovp_cnt_q + 11'h001;
      end else begin
        ovp_cnt_q <= 11'h000;
        if (ovp_fault_q && in_q[`IN_OVP_RST] && in_q[`IN_VCC_ON])
          ovp_fault_q <= 1'b0;
      end
      if (in_q[`IN_DIV_MISS])
        divider_latch_q <= 1'b1;
      else if (in_q[`IN_VCC_RST])
        divider_latch_q <= 1'b0;
      if (short_cnt_q == `SHORT_TRIP_COUNT)
        short_latch_q <= 1'b1;
      else if (in_q[`IN_VCC_RST])
        short_latch_q <= 1'b0;
    end
  end

  // switching cycle: on until ramp end, peak or short trip, off until zero crossing or timeout
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      gate_drive_q <= 1'b0;
      zcd_cnt_q <= 16'h0000;
      short_cnt_q <= 3'h0;
      short_seen_q <= 1'b0;
      stopped_q <= 1'b1;
    end else begin
      stopped_q <= any_stop;
      if (in_q[`IN_VCC_RST])
        short_cnt_q <= 3'h0;
      case (state_q)
        ST_IDLE: begin
          gate_drive_q <= 1'b0;
          if (!any_stop) begin
            state_q <= ST_ON;
            gate_drive_q <= 1'b1;
            short_seen_q <= 1'b0;
          end
        end
        ST_ON: begin
          if (rise[`IN_SHORT])
            short_seen_q <= 1'b1;
          if (any_stop) begin
            state_q <= ST_IDLE;
            gate_drive_q <= 1'b0;
          end else if (in_q[`IN_TON_END] || in_q[`IN_PEAK] || rise[`IN_SHORT]) begin
            state_q <= ST_OFF;
            gate_drive_q <= 1'b0;
            zcd_cnt_q <= 16'h0000;
            // consecutive trips only; a clean cycle restarts the count
            if ((short_seen_q || rise[`IN_SHORT]) && short_cnt_q != `SHORT_TRIP_COUNT)
              short_cnt_q <= short_cnt_q + 3'h1;
            else if (!(short_seen_q || rise[`IN_SHORT]))
              short_cnt_q <= 3'h0;
          end
        end
        ST_OFF: begin
          gate_drive_q <= 1'b0;
          if (any_stop) begin
            state_q <= ST_IDLE;
          end else if (rise[`IN_ZCD] ||
                       zcd_cnt_q >= ZCD_TIMEOUT_CYCLES[15:0] - 16'h0001) begin
            // low sense current can hide the zero crossing; restart anyway
            state_q <= ST_ON;
            gate_drive_q <= 1'b1;
            short_seen_q <= 1'b0;
          end else begin
            zcd_cnt_q <= zcd_cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          gate_drive_q <= 1'b0;
        end
      endcase
    end
  end
endmodule // dimming_angle_and_fault_control

// [tb/dimming_checker_asserts.sv]
// port-level assertions for the dimming supervisor
module dimming_checker #(
  parameter TF_BLANK_CYCLES = 50,
  parameter ZCD_TIMEOUT_CYCLES = 40
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // watched inputs
  input wire ovp_above_off,
  input wire ovp_below_on,
  input wire divider_missing,
  input wire supply_on,
  input wire supply_reset,
  // watched outputs
  input wire gate_drive_q,
  input wire [7:0] reference_code_q,
  input wire [7:0] peak_setpoint_q,
  input wire ovp_fault_q,
  input wire short_latch_q,
  input wire divider_latch_q,
  input wire thermal_stop_q,
  input wire stopped_q
);
  reg [11:0] ovp_q;
  reg [7:0] idle_q;
  reg [15:0] on_q;
  // saturating so long runs never wrap into a false pass
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovp_q <= 12'h000;
      idle_q <= 8'h00;
      on_q <= 16'h0000;
    end else begin
      ovp_q <= !ovp_above_off ? 12'h000 : (&ovp_q ? ovp_q : ovp_q + 12'h001);
      idle_q <= (gate_drive_q || stopped_q) ? 8'h00 : (&idle_q ? idle_q : idle_q + 8'h01);
      on_q <= !supply_on ? 16'h0000 : (&on_q ? on_q : on_q + 16'h0001);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_GATE_OFF: assert property (
    (stopped_q || ovp_fault_q || short_latch_q || divider_latch_q || thermal_stop_q) [*2]
    |-> !gate_drive_q) else $error("gate on while stopped");
  AST_SETPOINT_FLOOR: assert property (
    $stable(reference_code_q) [*2] |-> peak_setpoint_q ==
    ((reference_code_q > 8'h59) ? reference_code_q : 8'h59)) else $error("bad set-point");
  AST_DIV_SET: assert property (
    $rose(divider_missing) |-> ##[1:8] divider_latch_q) else $error("divider latch late");
  AST_DIV_HOLD: assert property (
    (divider_latch_q && !supply_reset) [*6] |=> divider_latch_q) else $error("divider lost");
  AST_SHORT_HOLD: assert property (
    (short_latch_q && !supply_reset) [*6] |=> short_latch_q) else $error("short latch lost");
  AST_OVP_QUAL: assert property (
    $rose(ovp_fault_q) |-> ovp_q >= 12'd2000) else $error("overvoltage too early");
  AST_OVP_CLEAR: assert property (
    $fell(ovp_fault_q) |-> $past(ovp_below_on, 3) && $past(supply_on, 3))
    else $error("overvoltage cleared early");
  AST_ZCD_TIMEOUT: assert property (
    idle_q <= ZCD_TIMEOUT_CYCLES + 12) else $error("no restart after timeout");
  AST_TF_BLANK: assert property (
    $rose(thermal_stop_q) |-> on_q >= TF_BLANK_CYCLES) else $error("thermal not blanked");
endmodule // dimming_checker

bind dimming_angle_and_fault_control dimming_checker #(
  .TF_BLANK_CYCLES(TF_BLANK_CYCLES),
  .ZCD_TIMEOUT_CYCLES(ZCD_TIMEOUT_CYCLES)
) u_chk (.ref_clk, .rst_n, .ovp_above_off, .ovp_below_on, .divider_missing, .supply_on,
  .supply_reset, .gate_drive_q, .reference_code_q, .peak_setpoint_q, .ovp_fault_q,
  .short_latch_q, .divider_latch_q, .thermal_stop_q, .stopped_q);

// [tb/converter_model.sv]
// mains and power stage stand-in driving the comparator inputs
module converter_model (
  // clock
  input wire ref_clk,
  // bench control
  input wire run,
  input wire zcd_en,
  input wire [7:0] cond_len,
  // gate from the design
  input wire gate_drive_q,
  // comparator outputs
  output reg mains_valley_input,
  output reg conduction_sense_input,
  output reg on_time_end,
  output reg zero_crossing_event
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  int on_n = 0;
  int off_n = 0;
  initial begin
    {mains_valley_input, conduction_sense_input, on_time_end, zero_crossing_event} = 4'h0;
  end
  // half period of 100 cycles, valley marks its start
  always @(posedge ref_clk) begin
    ph <= run ? (ph + 1) % 100 : 0;
    mains_valley_input <= run && ph < 4;
    conduction_sense_input <= run && ph < cond_len;
    on_n <= gate_drive_q ? on_n + 1 : 0;
    off_n <= gate_drive_q ? 0 : off_n + 1;
    on_time_end <= gate_drive_q && on_n >= 10;
    zero_crossing_event <= zcd_en && off_n >= 20;
  end
endmodule // converter_model

// [tb/dimming_angle_and_fault_control_tb.sv]
// self-checking bench for the dimming supervisor
module dimming_angle_and_fault_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg ref_clk, rst_n, run, zcd_en, peak_trip, winding_short_trip, ovp_above_off;
  reg ovp_below_on, divider_missing, supply_on, supply_reset;
  reg [7:0] thermal_sense_input, cond_len;
  wire mains_valley_input, conduction_sense_input, on_time_end, zero_crossing_event;
  wire gate_drive_q, ovp_fault_q, short_latch_q, divider_latch_q, thermal_stop_q, stopped_q;
  wire [7:0] conduction_angle_q, reference_code_q, peak_setpoint_q;
  int error_cnt, num_checks, n;

  dimming_angle_and_fault_control #(.TF_BLANK_CYCLES(50), .ZCD_TIMEOUT_CYCLES(40)) u_dut (
    .ref_clk, .rst_n, .conduction_sense_input, .mains_valley_input, .on_time_end,
    .peak_trip, .winding_short_trip, .zero_crossing_event, .ovp_above_off, .ovp_below_on,
    .divider_missing, .supply_on, .supply_reset, .thermal_sense_input, .gate_drive_q,
    .conduction_angle_q, .reference_code_q, .peak_setpoint_q, .ovp_fault_q,
    .short_latch_q, .divider_latch_q, .thermal_stop_q, .stopped_q);
  converter_model u_model (.ref_clk, .run, .zcd_en, .cond_len, .gate_drive_q,
    .mains_valley_input, .conduction_sense_input, .on_time_end, .zero_crossing_event);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // bounded wait; a hang ends the run
  task automatic wait_gate(input logic v, input int lim, output int k);
    k = 0;
    while (gate_drive_q !== v && k < lim) begin
      cyc(1);
      k++;
    end
    if (gate_drive_q !== v) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, gate_drive_q, v);
      complete_run;
    end
  endtask

  task automatic pulse_reset;
    @(posedge ref_clk) supply_reset <= 1'b1;
    cyc(10);
    @(posedge ref_clk) supply_reset <= 1'b0;
    cyc(10);
  endtask

  task automatic t_reset;
    chk(gate_drive_q, 8'h00);
    chk(peak_setpoint_q, 8'h59);
    chk(stopped_q, 8'h01);
    chk({ovp_fault_q, short_latch_q, divider_latch_q, thermal_stop_q}, 8'h00);
  endtask

  task automatic t_zcd;
    wait_gate(1, 200, n);
    wait_gate(0, 40, n);
    wait_gate(1, 60, n);
    chk_rng(n[7:0], 8'd20, 8'd36);
    @(posedge ref_clk) zcd_en <= 1'b0;
    wait_gate(0, 40, n);
    wait_gate(1, 80, n);
    chk_rng(n[7:0], 8'd38, 8'd50);
    @(posedge ref_clk) zcd_en <= 1'b1;
    wait_gate(1, 80, n);
    @(posedge ref_clk) peak_trip <= 1'b1;
    wait_gate(0, 40, n);
    chk_rng(n[7:0], 8'd3, 8'd8);
    @(posedge ref_clk) peak_trip <= 1'b0;
  endtask

  task automatic t_short;
    repeat (4) begin
      wait_gate(1, 80, n);
      @(posedge ref_clk) winding_short_trip <= 1'b1;
      cyc(4);
      @(posedge ref_clk) winding_short_trip <= 1'b0;
      wait_gate(0, 40, n);
    end
    cyc(10);
    chk(short_latch_q, 8'h01);
    cyc(100);
    chk(gate_drive_q, 8'h00);
    pulse_reset;
    chk(short_latch_q, 8'h00);
  endtask

  task automatic t_ovp;
    @(posedge ref_clk) {ovp_above_off, ovp_below_on} <= 2'b10;
    cyc(1990);
    chk(ovp_fault_q, 8'h00);
    cyc(30);
    chk(ovp_fault_q, 8'h01);
    chk(gate_drive_q, 8'h00);
    // hysteresis band must not restart
    @(posedge ref_clk) ovp_above_off <= 1'b0;
    cyc(20);
    chk(ovp_fault_q, 8'h01);
    @(posedge ref_clk) ovp_below_on <= 1'b1;
    cyc(10);
    chk(ovp_fault_q, 8'h00);
  endtask

  task automatic t_div;
    @(posedge ref_clk) divider_missing <= 1'b1;
    cyc(8);
    chk(divider_latch_q, 8'h01);
    @(posedge ref_clk) divider_missing <= 1'b0;
    cyc(30);
    chk(divider_latch_q, 8'h01);
    chk(gate_drive_q, 8'h00);
    pulse_reset;
    chk(divider_latch_q, 8'h00);
  endtask

  task automatic t_angle;
    @(posedge ref_clk) begin
      cond_len <= 8'd50;
      run <= 1'b1;
    end
    cyc(2000);
    chk(conduction_angle_q, 8'h00);
    cyc(5000);
    chk_rng(conduction_angle_q, 8'h7c, 8'h84);
    chk_rng(reference_code_q, 8'h7c, 8'h84);
    chk_rng(peak_setpoint_q, 8'h7c, 8'h84);
  endtask

  task automatic t_therm;
    @(posedge ref_clk) thermal_sense_input <= 8'h40;
    cyc(10);
    chk_rng(reference_code_q, 8'h0b, 8'h0f);
    chk(peak_setpoint_q, 8'h59);
    @(posedge ref_clk) thermal_sense_input <= 8'h00;
    cyc(10);
    chk(thermal_stop_q, 8'h01);
    cyc(5);
    chk(gate_drive_q, 8'h00);
    @(posedge ref_clk) thermal_sense_input <= 8'hff;
    cyc(10);
    chk(thermal_stop_q, 8'h00);
    chk_rng(reference_code_q, 8'h7c, 8'h84);
  endtask

  task automatic t_blank;
    @(posedge ref_clk) supply_on <= 1'b0;
    cyc(10);
    @(posedge ref_clk) {thermal_sense_input, supply_on} <= {8'h00, 1'b1};
    cyc(35);
    chk(thermal_stop_q, 8'h00);
    cyc(40);
    chk(thermal_stop_q, 8'h01);
  endtask

  initial begin
    error_cnt = 0;
    num_checks = 0;
    {rst_n, run, peak_trip, winding_short_trip, ovp_above_off} = 5'h00;
    {divider_missing, supply_reset, zcd_en, ovp_below_on, supply_on} = 5'h07;
    thermal_sense_input = 8'hff;
    cond_len = 8'h00;
    cyc(4);
    t_reset;
    @(posedge ref_clk) rst_n <= 1'b1;
    t_zcd;
    t_short;
    t_ovp;
    t_div;
    t_angle;
    t_therm;
    t_blank;
    complete_run;
  end
endmodule // dimming_angle_and_fault_control_tb
